// ==== src/ksd_decoder.sv ====
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ksd_decoder (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic va_valid,
   input wire logic [63:0] va,
   input wire logic exc_take,
   input wire logic exception_return,
   output logic res_valid,
   output logic [3:0] seg_class,
   output logic tlb_req,
   output logic addr_err,
   output logic uncached,
   output logic [31:0] paddr,
   output logic tag_valid,
   output logic [7:0] tag_out,
   output logic kernel_mode
);

   function automatic logic [35:0] decode(
      input logic [63:0] a,
      input logic km,
      input logic kw,
      input logic sw,
      input logic error_level_flag,
      input logic cac
   );
      logic [63:0] v;
      ksd_pkg::ksd_class_t c;
      ksd_pkg::ksd_class_t dc;
      logic [31:0] p;
      v = a;
      c = ksd_pkg::KSD_CL_ERR;
      p = 32'h0000_0000;
      dc = cac ? ksd_pkg::KSD_CL_CAC : ksd_pkg::KSD_CL_UNC;
      if (km && kw) begin
         case (v[63:62])
            2'b00, 2'b01: begin
               if (v[61:40] == 22'h00_0000) begin
                  c = ksd_pkg::KSD_CL_MAP;
               end
            end
            2'b10: begin
               // window index in 61:59 is free; 58:32 must be zero
               if (v[58:32] == 27'h000_0000) begin
                  c = ksd_pkg::KSD_CL_CAC;
                  p = v[31:0];
               end
            end
            default: begin
               if (v[63:31] == ksd_pkg::COMPAT_TOP) begin
                  case (v[30:29])
                     2'b00: begin
                        c = dc;
                        p = v[31:0] - ksd_pkg::CACHED_BASE;
                     end
                     2'b01: begin
                        c = ksd_pkg::KSD_CL_UNC;
                        p = v[31:0] - ksd_pkg::UNCACHED_BASE;
                     end
                     default: c = ksd_pkg::KSD_CL_MAP;
                  endcase
               end else if (v[61:40] == 22'h00_0000 &&
                            v[39:31] != ksd_pkg::XKSEG_HOLE) begin
                  c = ksd_pkg::KSD_CL_MAP;
               end
               // everything else in this quarter stays error
            end
         endcase
      end else if (km) begin
         v = {{32{a[31]}}, a[31:0]};
         case (v[31:29])
            3'b100: begin
               c = dc;
               p = v[31:0] - ksd_pkg::CACHED_BASE;
            end
            3'b101: begin
               c = ksd_pkg::KSD_CL_UNC;
               p = v[31:0] - ksd_pkg::UNCACHED_BASE;
            end
            3'b110, 3'b111: c = ksd_pkg::KSD_CL_MAP;
            default: begin
               if (error_level_flag) begin
                  c = ksd_pkg::KSD_CL_UNC;
                  p = v[31:0];
               end else begin
                  c = ksd_pkg::KSD_CL_MAP;
               end
            end
         endcase
      end else if (sw) begin
         if ((v[63:62] == 2'b00 || v[63:62] == 2'b01) &&
             v[61:40] == 22'h00_0000) begin
            c = ksd_pkg::KSD_CL_MAP;
         end else if (v[63:29] == ksd_pkg::CSSEG_TOP) begin
            c = ksd_pkg::KSD_CL_MAP;
         end
      end else begin
         // narrow user/supervisor maps are outside this block:
         // only the low 2 GB is let through to the TLB
         v = {{32{a[31]}}, a[31:0]};
         if (!v[31]) begin
            c = ksd_pkg::KSD_CL_MAP;
         end
      end
      decode = {c, p};
   endfunction : decode

   // status, tag and attribute state
   logic [1:0] priv_q, priv_d;
   logic exl_q, exl_d;
   logic erl_q, erl_d;
   logic sw_q, sw_d;
   logic kw_q, kw_d;
   logic [7:0] tag_q, tag_d;
   logic [2:0] attr_q, attr_d;
   // bus state
   logic wr_q, wr_d;
   logic [7:0] wa_q, wa_d;
   logic [31:0] rd_q, rd_d;
   // result state
   logic rv_q, rv_d;
   ksd_pkg::ksd_class_t cl_q, cl_d;
   logic [31:0] pa_q, pa_d;
   logic tv_q, tv_d;
   logic [7:0] to_q, to_d;
   logic km_q, km_d;
   logic ae_q, ae_d;
   logic un_q, un_d;

   logic kmode;
   logic take;
   logic [35:0] dec;

   assign kmode = (priv_q == ksd_pkg::PRIV_KERNEL) || exl_q || erl_q;
   assign take = hsel && htrans[1] && hready;
   // decode in the presentation cycle: all 64 bits of va in wide modes, only va[31:0] in narrow ones
   assign dec = decode(va, kmode, kw_q, sw_q, erl_q,
                       attr_q != ksd_pkg::ATTR_UNCACHED);

   always_comb begin
      priv_d = priv_q;
      exl_d = exl_q;
      erl_d = erl_q;
      sw_d = sw_q;
      kw_d = kw_q;
      tag_d = tag_q;
      attr_d = attr_q;
      if (wr_q && wa_q == ksd_pkg::OFF_STATUS) begin
         priv_d = hwdata[ksd_pkg::ST_PRIV_LO +: 2];
         exl_d = hwdata[ksd_pkg::ST_EXL];
         erl_d = hwdata[ksd_pkg::ST_ERL];
         sw_d = hwdata[ksd_pkg::ST_SWIDE];
         kw_d = hwdata[ksd_pkg::ST_KWIDE];
      end
      if (wr_q && wa_q == ksd_pkg::OFF_TAG) begin
         tag_d = hwdata[7:0];
      end
      if (wr_q && wa_q == ksd_pkg::OFF_CONFIG) begin
         attr_d = hwdata[2:0];
      end
      // hardware events beat a software write in the same cycle;
      // privilege is left alone so the return restores it
      if (exc_take) begin
         exl_d = 1'b1;
      end else if (exception_return) begin
         if (erl_q) begin
            erl_d = 1'b0;
         end else begin
            exl_d = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         priv_q <= ksd_pkg::PRIV_RST;
         exl_q <= ksd_pkg::EXL_RST;
         erl_q <= ksd_pkg::ERL_RST;
         sw_q <= ksd_pkg::SWIDE_RST;
         kw_q <= ksd_pkg::KWIDE_RST;
         tag_q <= ksd_pkg::TAG_RST;
         attr_q <= ksd_pkg::ATTR_RST;
      end else begin
         priv_q <= priv_d;
         exl_q <= exl_d;
         erl_q <= erl_d;
         sw_q <= sw_d;
         kw_q <= kw_d;
         tag_q <= tag_d;
         attr_q <= attr_d;
      end
   end

   // zero-wait slave: read data is sampled at the address phase
   always_comb begin
      wr_d = take && hwrite;
      wa_d = take ? haddr[7:0] : wa_q;
      rd_d = 32'h0000_0000;
      if (take && !hwrite) begin
         case (haddr[7:0])
            ksd_pkg::OFF_STATUS: begin
               rd_d[ksd_pkg::ST_PRIV_LO +: 2] = priv_q;
               rd_d[ksd_pkg::ST_EXL] = exl_q;
               rd_d[ksd_pkg::ST_ERL] = erl_q;
               rd_d[ksd_pkg::ST_SWIDE] = sw_q;
               rd_d[ksd_pkg::ST_KWIDE] = kw_q;
            end
            ksd_pkg::OFF_TAG: rd_d[7:0] = tag_q;
            ksd_pkg::OFF_CONFIG: rd_d[2:0] = attr_q;
            ksd_pkg::OFF_RESULT: rd_d[5:0] = {km_q, rv_q, cl_q};
            ksd_pkg::OFF_PADDR: rd_d = pa_q;
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rd_q <= 32'h0000_0000;
      end else begin
         wr_q <= wr_d;
         wa_q <= wa_d;
         rd_q <= rd_d;
      end
   end

   always_comb begin
      rv_d = va_valid;
      cl_d = cl_q;
      pa_d = pa_q;
      tv_d = 1'b0;
      to_d = to_q;
      km_d = kmode;
      ae_d = 1'b0;
      un_d = 1'b0;
      if (va_valid) begin
         cl_d = ksd_pkg::ksd_class_t'(dec[35:32]);
         pa_d = dec[31:0];
         // mapped references carry the tag to the TLB
         tv_d = dec[35:32] == ksd_pkg::KSD_CL_MAP;
         to_d = tag_q;
         ae_d = dec[35:32] == ksd_pkg::KSD_CL_ERR;
         un_d = dec[35:32] == ksd_pkg::KSD_CL_UNC;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rv_q <= 1'b0;
         cl_q <= ksd_pkg::KSD_CL_ERR;
         pa_q <= 32'h0000_0000;
         tv_q <= 1'b0;
         to_q <= 8'h00;
         km_q <= 1'b1;
         ae_q <= 1'b0;
         un_q <= 1'b0;
      end else begin
         rv_q <= rv_d;
         cl_q <= cl_d;
         pa_q <= pa_d;
         tv_q <= tv_d;
         to_q <= to_d;
         km_q <= km_d;
         ae_q <= ae_d;
         un_q <= un_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   assign res_valid = rv_q;
   assign seg_class = cl_q;
   // lookup only for valid mapped results, never on error
   assign tlb_req = tv_q;
   assign addr_err = ae_q;
   assign uncached = un_q;
   assign paddr = pa_q;
   assign tag_valid = tv_q;
   assign tag_out = to_q;
   assign kernel_mode = km_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_err_no_lookup: assert property (
      addr_err |-> !tlb_req)
      else $error("lookup raised on address error");
   a_exc_enters_kernel: assert property (
      exc_take |=> exl_q ##1 kernel_mode)
      else $error("exception did not enter kernel mode");
   a_ret_clears_erl: assert property (
      exception_return && !exc_take && erl_q |=> !erl_q && $stable(priv_q))
      else $error("return did not clear error level");
   a_kmode_follows: assert property (
      (priv_q == 2'h0 || exl_q || erl_q) |=> kernel_mode)
      else $error("kernel mode not reported");
   a_tag_on_map: assert property (
      va_valid && dec[35:32] == 4'b0001
      |=> tag_valid && tag_out == $past(tag_q))
      else $error("tag missing on mapped reference");
   a_cached_window_pa: assert property (
      va_valid && kmode && !kw_q && va[31:29] == 3'b100
      |=> paddr == $past(va[31:0]) - 32'h8000_0000)
      else $error("cached window address wrong");
   a_uncached_window: assert property (
      va_valid && kmode && !kw_q && va[31:29] == 3'b101 |=> uncached)
      else $error("uncached window not uncached");
   a_phys_hole_err: assert property (
      va_valid && kmode && kw_q && va[63:62] == 2'b10 && va[58:32] != 0
      |=> addr_err && !tlb_req)
      else $error("direct region hole not an error");
   a_user_gap_err: assert property (
      va_valid && kmode && kw_q && va[63:62] == 2'b00 && va[61:40] != 0
      |=> addr_err)
      else $error("user gap not an error");
   a_ret_clears_exl: assert property (
      exception_return && !exc_take && !erl_q && !wr_q
      |=> !exl_q && $stable(priv_q))
      else $error("return did not clear exception level");
   a_exc_beats_ret: assert property (
      exc_take && exception_return |=> exl_q)
      else $error("exception lost to a return");
   a_erl_identity: assert property (
      va_valid && kmode && !kw_q && erl_q && !va[31]
      |=> uncached && paddr == $past(va[31:0]))
      else $error("error level user space not identity");
   a_compat_uncached: assert property (
      va_valid && kmode && kw_q && va[63:29] == 35'h7_FFFF_FFFD
      |=> uncached && !tlb_req)
      else $error("compat uncached window not uncached");
endmodule : ksd_decoder
`default_nettype wire

// ==== src/ksd_pkg.sv ====
`default_nettype none
package ksd_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_TAG = 8'h04;
   localparam logic [7:0] OFF_CONFIG = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0C;
   localparam logic [7:0] OFF_PADDR = 8'h10;
   // status field positions
   localparam int ST_PRIV_LO = 0;
   localparam int ST_EXL = 2;
   localparam int ST_ERL = 3;
   localparam int ST_SWIDE = 4;
   localparam int ST_KWIDE = 5;
   // reset values
   localparam logic [1:0] PRIV_RST = 2'h0;
   localparam logic EXL_RST = 1'b0;
   localparam logic ERL_RST = 1'b1;
   localparam logic SWIDE_RST = 1'b0;
   localparam logic KWIDE_RST = 1'b0;
   localparam logic [7:0] TAG_RST = 8'h00;
   localparam logic [2:0] ATTR_RST = 3'h2;
   // attribute code that means uncached
   localparam logic [2:0] ATTR_UNCACHED = 3'h2;
   localparam logic [1:0] PRIV_KERNEL = 2'h0;
   // segment bases and high-bit patterns
   localparam logic [31:0] CACHED_BASE = 32'h8000_0000;
   localparam logic [31:0] UNCACHED_BASE = 32'hA000_0000;
   localparam logic [32:0] COMPAT_TOP = 33'h1_FFFF_FFFF;
   localparam logic [34:0] CSSEG_TOP = 35'h7_FFFF_FFFE;
   localparam logic [8:0] XKSEG_HOLE = 9'h1FF;
   typedef enum logic [3:0] {
      KSD_CL_MAP = 4'b0001,
      KSD_CL_CAC = 4'b0010,
      KSD_CL_UNC = 4'b0100,
      KSD_CL_ERR = 4'b1000
   } ksd_class_t;
endpackage : ksd_pkg
`default_nettype wire

// ==== verification/ksd_agen_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ksd_agen_model (
   input wire logic core_clk,
   input wire logic req,
   input wire logic [63:0] base,
   input wire logic [15:0] offset,
   output logic va_valid,
   output logic [63:0] va
);
   logic [63:0] sum;
   // bench keeps base plus offset clear of 32-bit overflow
   assign sum = base + {{48{offset[15]}}, offset};
   initial begin
      va_valid = 1'b0;
      va = 64'h0000_0000_0000_0000;
   end
   always @(posedge core_clk) begin
      va_valid <= req;
      // idle address scrambles so nothing leans on a stale value
      va <= req ? sum : ~va;
   end
endmodule : ksd_agen_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   typedef struct {
      logic [5:0] st;
      logic [63:0] va;
      logic [3:0] cl;
      logic [31:0] pa;
      logic km;
   } ksd_row_t;
   localparam logic [3:0] cm = ksd_pkg::KSD_CL_MAP;
   localparam logic [3:0] cc = ksd_pkg::KSD_CL_CAC;
   localparam logic [3:0] cu = ksd_pkg::KSD_CL_UNC;
   localparam logic [3:0] ce = ksd_pkg::KSD_CL_ERR;
   logic core_clk, srst, hsel, hwrite, hreadyout, hresp, req, va_valid;
   logic exc_take, exception_return, res_valid, tlb_req, addr_err;
   logic uncached, tag_valid, kernel_mode;
   logic [31:0] haddr, hwdata, hrdata, paddr, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [63:0] base, va;
   logic [3:0] seg_class;
   logic [7:0] tag_out;
   logic [5:0] cur_st;
   int fails, compares;
   ksd_row_t rows[$];

   ksd_decoder i_ksd_decoder (.core_clk(core_clk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .va_valid(va_valid), .va(va), .exc_take(exc_take),
      .exception_return(exception_return), .res_valid(res_valid),
      .seg_class(seg_class), .tlb_req(tlb_req), .addr_err(addr_err),
      .uncached(uncached), .paddr(paddr), .tag_valid(tag_valid),
      .tag_out(tag_out), .kernel_mode(kernel_mode));
   ksd_agen_model i_ksd_agen_model (.core_clk(core_clk), .req(req),
      .base(base), .offset(16'h0000), .va_valid(va_valid), .va(va));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic end_sim();
      if (fails == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   task automatic cmp_bit(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %b got %b", n, e, g);
      end
   endtask : cmp_bit

   task automatic cmp_word(input string n, input logic [31:0] e,
         input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp_word

   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      d = hrdata;
   endtask : ahb

   task automatic check(input ksd_row_t r);
      logic [31:0] d;
      if (r.st !== cur_st) begin
         ahb(1'b1, ksd_pkg::OFF_STATUS, 32'(r.st), d);
         cur_st = r.st;
      end
      @(posedge core_clk);
      req <= 1'b1;
      base <= r.va;
      @(posedge core_clk);
      req <= 1'b0;
      @(posedge core_clk);
      #1;
      cmp_bit("res_valid", 1'b1, res_valid);
      cmp_word("class", 32'(r.cl), 32'(seg_class));
      cmp_word("paddr", r.pa, paddr);
      cmp_bit("tlb_req", r.cl === cm, tlb_req);
      cmp_bit("tag_valid", r.cl === cm, tag_valid);
      cmp_bit("addr_err", r.cl === ce, addr_err);
      cmp_bit("uncached", r.cl === cu, uncached);
      cmp_bit("kernel_mode", r.km, kernel_mode);
      if (r.cl === cm)
         cmp_word("tag_out", 32'h0000_005A, 32'(tag_out));
   endtask : check

   function automatic void add(logic [5:0] s, logic [63:0] v,
         logic [3:0] c, logic [31:0] p, logic k);
      rows.push_back('{s, v, c, p, k});
   endfunction : add

   task automatic pulse(input logic e, input logic r);
      @(posedge core_clk);
      exc_take <= e;
      exception_return <= r;
      @(posedge core_clk);
      exc_take <= 1'b0;
      exception_return <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : pulse

   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      end_sim();
   end

   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      req = 1'b0;
      base = 64'h0000_0000_0000_0000;
      exc_take = 1'b0;
      exception_return = 1'b0;
      cur_st = 6'h3F;
      add(6'h20, 64'hFFFF_FFFF_8000_0010, cc, 32'h0000_0010, 1'b1);
      add(6'h20, 64'hFFFF_FFFF_A000_0020, cu, 32'h0000_0020, 1'b1);
      add(6'h20, 64'hFFFF_FFFF_C000_0000, cm, 32'h0000_0000, 1'b1);
      add(6'h20, 64'hFFFF_FFFF_E000_0000, cm, 32'h0000_0000, 1'b1);
      add(6'h20, 64'hFFFF_FFFF_7FFF_FFFF, ce, 32'h0000_0000, 1'b1);
      add(6'h20, 64'hC000_00FF_8000_0000, ce, 32'h0000_0000, 1'b1);
      add(6'h20, 64'hC000_00FF_7FFF_FFFF, cm, 32'h0000_0000, 1'b1);
      add(6'h20, 64'h4000_00FF_FFFF_FFFF, cm, 32'h0000_0000, 1'b1);
      add(6'h20, 64'h4000_0100_0000_0000, ce, 32'h0000_0000, 1'b1);
      add(6'h20, 64'h0000_00FF_FFFF_FFFF, cm, 32'h0000_0000, 1'b1);
      add(6'h20, 64'h0000_0100_0000_0000, ce, 32'h0000_0000, 1'b1);
      add(6'h20, 64'hB800_0000_1234_5678, cc, 32'h1234_5678, 1'b1);
      add(6'h20, 64'h8800_0000_FFFF_FFFF, cc, 32'hFFFF_FFFF, 1'b1);
      add(6'h20, 64'h8000_0001_0000_0000, ce, 32'h0000_0000, 1'b1);
      add(6'h00, 64'h0000_0000_7FFF_FFF0, cm, 32'h0000_0000, 1'b1);
      add(6'h00, 64'hFFFF_FFFF_8000_0040, cc, 32'h0000_0040, 1'b1);
      add(6'h00, 64'hFFFF_FFFF_A000_0040, cu, 32'h0000_0040, 1'b1);
      add(6'h00, 64'h0000_0000_8000_0044, cc, 32'h0000_0044, 1'b1);
      add(6'h08, 64'h0000_0000_1000_0000, cu, 32'h1000_0000, 1'b1);
      add(6'h11, 64'hFFFF_FFFF_C000_0000, cm, 32'h0000_0000, 1'b0);
      add(6'h11, 64'hFFFF_FFFF_E000_0000, ce, 32'h0000_0000, 1'b0);
      add(6'h15, 64'hFFFF_FFFF_A000_0004, cu, 32'h0000_0004, 1'b1);
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      cmp_bit("kernel_mode", 1'b1, kernel_mode);
      cmp_word("class", 32'(ce), 32'(seg_class));
      ahb(1'b0, ksd_pkg::OFF_STATUS, 32'h0000_0000, rd);
      cmp_word("status", 32'h0000_0008, rd);
      ahb(1'b0, ksd_pkg::OFF_CONFIG, 32'h0000_0000, rd);
      cmp_word("config", 32'h0000_0002, rd);
      ahb(1'b0, 8'h20, 32'h0000_0000, rd);
      cmp_word("unmapped", 32'h0000_0000, rd);
      ahb(1'b1, ksd_pkg::OFF_TAG, 32'h0000_005A, rd);
      ahb(1'b1, ksd_pkg::OFF_CONFIG, 32'h0000_0003, rd);
      foreach (rows[i])
         check(rows[i]);
      ahb(1'b1, ksd_pkg::OFF_CONFIG, 32'h0000_0002, rd);
      add(6'h20, 64'hFFFF_FFFF_8000_0010, cu, 32'h0000_0010, 1'b1);
      check(rows[$]);
      ahb(1'b0, ksd_pkg::OFF_PADDR, 32'h0000_0000, rd);
      cmp_word("paddr_reg", 32'h0000_0010, rd);
      ahb(1'b0, ksd_pkg::OFF_RESULT, 32'h0000_0000, rd);
      cmp_word("result", 32'h0000_0024, rd);
      ahb(1'b1, ksd_pkg::OFF_STATUS, 32'h0000_0001, rd);
      pulse(1'b0, 1'b0);
      cmp_bit("kernel_mode", 1'b0, kernel_mode);
      pulse(1'b1, 1'b0);
      cmp_bit("kernel_mode", 1'b1, kernel_mode);
      ahb(1'b0, ksd_pkg::OFF_STATUS, 32'h0000_0000, rd);
      cmp_word("status", 32'h0000_0005, rd);
      pulse(1'b0, 1'b1);
      cmp_bit("kernel_mode", 1'b0, kernel_mode);
      ahb(1'b0, ksd_pkg::OFF_STATUS, 32'h0000_0000, rd);
      cmp_word("status", 32'h0000_0001, rd);
      pulse(1'b1, 1'b1);
      cmp_bit("kernel_mode", 1'b1, kernel_mode);
      ahb(1'b1, ksd_pkg::OFF_STATUS, 32'h0000_0009, rd);
      pulse(1'b0, 1'b1);
      cmp_bit("kernel_mode", 1'b0, kernel_mode);
      ahb(1'b0, ksd_pkg::OFF_STATUS, 32'h0000_0000, rd);
      cmp_word("status", 32'h0000_0001, rd);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      cmp_bit("kernel_mode", 1'b1, kernel_mode);
      ahb(1'b0, ksd_pkg::OFF_TAG, 32'h0000_0000, rd);
      cmp_word("tag", 32'h0000_0000, rd);
      ahb(1'b0, ksd_pkg::OFF_STATUS, 32'h0000_0000, rd);
      cmp_word("status", 32'h0000_0008, rd);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
